// *** core/pll_divider_and_lock_detect.sv ***
// Clock synthesis dividers, lock detector and APB configuration registers
`timescale 1ns/1ns
`include "pll_cfg.svh"
module pll_divider_and_lock_detect (
	input  wire logic        clk,         // System clock, 25 MHz
	input  wire logic        rst,         // Synchronous reset, active high
	input  wire logic        psel,        // APB select
	input  wire logic        penable,     // APB enable
	input  wire logic        pwrite,      // APB write
	input  wire logic [7:0]  paddr,       // APB byte address
	input  wire logic [31:0] pwdata,      // APB write data
	output logic      [31:0] prdata,      // APB read data
	output logic             pready,      // APB ready
	output logic             pslverr,     // APB error on unmapped address
	input  wire logic        ref_in,      // Selected reference clock pin
	input  wire logic        osc_in,      // Oscillator clock
	input  wire logic        bypass_in,   // Loop bypass control pin
	output logic [4:0]       clk_out,     // Output divider clocks
	output logic             lock_n,      // Lock indication, low when locked
	output logic [3:0]       cp_code,     // Charge-pump current code
	output logic [2:0]       res_code,    // Loop filter resistor code
	output logic             coarse_skew  // Coarse skew mode select
);
	import pll_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [31:0] prescale;
		logic [31:0] out_div;
		logic [31:0] loop_cfg;
		logic [31:0] rdata;
		lock_state_t lk;
		logic [8:0]  qual;
		logic        pend_ref;
		logic        pend_fbk;
		logic [2:0]  win;
		logic [1:0]  fcnt;
		logic [9:0]  ref_idle;
		logic        ref_lost;
		logic        lock_n;
	} top_st_t;

	top_st_t st_reg;
	top_st_t st_next;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic ref_rise;
	logic osc_rise;
	logic bypass;

	edge_sync u_ref_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   (ref_in),
		.level (),
		.rise  (ref_rise)
	);

	edge_sync u_osc_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   (osc_in),
		.level (),
		.rise  (osc_rise)
	);

	edge_sync u_byp_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   (bypass_in),
		.level (bypass),
		.rise  ()
	);

	// ****************************************************************
	// Dividers
	// ****************************************************************
	div_code_t  m_code;
	div_code_t  n_code;
	div_ratio_t m_ratio;
	div_ratio_t n_ratio;
	logic [2:0] fbk_sel;
	logic       m_rise;
	logic       n_rise;
	logic [4:0] v_rise;
	logic [4:0] v_clk;
	logic       fbk_rise;
	logic       v_src;

	assign m_code  = st_reg.prescale[`PS_M_LSB +: 5];
	assign n_code  = st_reg.prescale[`PS_N_LSB +: 5];
	assign m_ratio = {2'b00, m_code} + 7'h01;
	assign n_ratio = {2'b00, n_code} + 7'h01;
	assign fbk_sel = st_reg.loop_cfg[`LC_FBK_LSB +: 3];

	ratio_divider u_m_div (
		.clk     (clk),
		.rst     (rst),
		.src_en  (ref_rise),
		.ratio   (m_ratio),
		.high    ((m_ratio + 7'h01) >> 1),
		.clk_out (),
		.rise    (m_rise)
	);

	// In bypass the V dividers run from the prescaled reference
	assign v_src = bypass ? m_rise : osc_rise;

	generate
		for (genvar k = 0; k < `NUM_OUT; k++) begin : g_vdiv
			div_code_t  code;
			div_ratio_t ratio;
			div_ratio_t half;
			div_ratio_t high;

			assign code  = st_reg.out_div[k*`VD_FIELD_W +: `VD_FIELD_W];
			assign half  = {2'b00, code} + 7'h01;
			// Even ratio 2..64 normally, halved to 1..32 in bypass
			assign ratio = bypass ? half : {half[5:0], 1'b0};
			// Ratios of 4k+2 above 2 run one edge short of half high
			assign high  = (!bypass && half[0] && half != 7'h01) ? half - 7'h01
				: (bypass ? ((half + 7'h01) >> 1) : half);

			ratio_divider u_v_div (
				.clk     (clk),
				.rst     (rst),
				.src_en  (v_src),
				.ratio   (ratio),
				.high    (high),
				.clk_out (v_clk[k]),
				.rise    (v_rise[k])
			);
		end
	endgenerate

	// The feedback divider keeps driving its own output as well
	assign fbk_rise = v_rise[fbk_sel];

	ratio_divider u_n_div (
		.clk     (clk),
		.rst     (rst),
		.src_en  (fbk_rise),
		.ratio   (n_ratio),
		.high    ((n_ratio + 7'h01) >> 1),
		.clk_out (),
		.rise    (n_rise)
	);

	// ****************************************************************
	// Register access and lock detection
	// ****************************************************************
	logic       wr_en;
	logic       rd_setup;
	logic       addr_ok;
	logic       freq_mode;
	logic [8:0] qual_target;
	logic [8:0] qual_inc;
	logic       match;
	logic       mismatch;
	logic       freq_ok;
	logic [1:0] fbk_total;
	logic [31:0] wval;

	assign addr_ok   = (paddr == `ADDR_PRESCALE) || (paddr == `ADDR_OUT_DIV)
		|| (paddr == `ADDR_LOOP_CFG) || (paddr == `ADDR_STATUS);
	assign wr_en     = psel & penable & pwrite & addr_ok;
	assign rd_setup  = psel & ~penable & ~pwrite;
	assign freq_mode = st_reg.loop_cfg[`LC_MODE_BIT];
	assign qual_inc  = st_reg.qual + 9'h001;

	// Qualify count is code plus one, held inside 16..256
	always_comb begin
		qual_target = {1'b0, st_reg.loop_cfg[`LC_QUAL_LSB +: 8]} + 9'h001;
		if (qual_target < `QUAL_MIN) begin
			qual_target = `QUAL_MIN;
		end
	end

	always_comb begin
		st_next   = st_reg;
		match     = 1'b0;
		mismatch  = 1'b0;
		freq_ok   = 1'b0;
		fbk_total = st_reg.fcnt + {1'b0, n_rise};
		wval      = pwdata;

		// Register writes take effect in the access phase
		if (wr_en) begin
			unique case (paddr)
				`ADDR_PRESCALE: begin
					st_next.prescale = {19'h0, wval[12:8], 3'h0, wval[4:0]};
				end
				`ADDR_OUT_DIV: begin
					st_next.out_div = {7'h0, wval[24:0]};
				end
				`ADDR_LOOP_CFG: begin
					// Out-of-range selections clamp to the last legal setting
					if (wval[`LC_FBK_LSB +: 3] > `FBK_SEL_MAX) begin
						wval[`LC_FBK_LSB +: 3] = `FBK_SEL_MAX;
					end
					if (wval[`LC_CP_LSB +: 4] > `CP_CODE_MAX) begin
						wval[`LC_CP_LSB +: 4] = `CP_CODE_MAX;
					end
					if (wval[`LC_RES_LSB +: 3] > `RES_CODE_MAX) begin
						wval[`LC_RES_LSB +: 3] = `RES_CODE_MAX;
					end
					st_next.loop_cfg = {12'h0, wval[19:0]};
				end
				default: begin
				end
			endcase
		end

		// Read data is captured in the setup phase
		if (rd_setup) begin
			unique case (paddr)
				`ADDR_PRESCALE: st_next.rdata = st_reg.prescale;
				`ADDR_OUT_DIV:  st_next.rdata = st_reg.out_div;
				`ADDR_LOOP_CFG: st_next.rdata = st_reg.loop_cfg;
				`ADDR_STATUS: begin
					st_next.rdata = 32'h0;
					st_next.rdata[`ST_LOCK_BIT]   = ~st_reg.lock_n;
					st_next.rdata[`ST_BYPASS_BIT] = bypass;
					st_next.rdata[`ST_QUAL_LSB +: 9] = st_reg.qual;
				end
				default: st_next.rdata = 32'h0;
			endcase
		end

		// Rising-edge phase comparison within a short window
		if (m_rise && n_rise) begin
			match            = 1'b1;
			st_next.pend_ref = 1'b0;
			st_next.pend_fbk = 1'b0;
		end else if (m_rise) begin
			if (st_reg.pend_fbk) begin
				match            = 1'b1;
				st_next.pend_fbk = 1'b0;
			end else begin
				mismatch         = st_reg.pend_ref;
				st_next.pend_ref = 1'b1;
				st_next.win      = 3'h0;
			end
		end else if (n_rise) begin
			if (st_reg.pend_ref) begin
				match            = 1'b1;
				st_next.pend_ref = 1'b0;
			end else begin
				mismatch         = st_reg.pend_fbk;
				st_next.pend_fbk = 1'b1;
				st_next.win      = 3'h0;
			end
		end else if (st_reg.pend_ref || st_reg.pend_fbk) begin
			st_next.win = st_reg.win + 3'h1;
			if (st_next.win >= `PHASE_WIN_CYC) begin
				mismatch         = 1'b1;
				st_next.pend_ref = 1'b0;
				st_next.pend_fbk = 1'b0;
			end
		end

		// Reference watchdog on the prescaled reference
		if (m_rise) begin
			st_next.ref_idle = 10'h000;
			st_next.ref_lost = 1'b0;
		end else if (st_reg.ref_idle == `REF_LOSS_CYC) begin
			st_next.ref_lost = 1'b1;
		end else begin
			st_next.ref_idle = st_reg.ref_idle + 10'h001;
		end

		// Frequency check: exactly one feedback edge per reference period
		if (m_rise) begin
			freq_ok      = (fbk_total == 2'h1);
			st_next.fcnt = 2'h0;
		end else if (n_rise && st_reg.fcnt != 2'h3) begin
			st_next.fcnt = st_reg.fcnt + 2'h1;
		end

		// Lock state machine
		if (bypass) begin
			st_next.lk   = LK_IDLE;
			st_next.qual = 9'h000;
		end else if (!freq_mode) begin
			st_next.qual = 9'h000;
			if (mismatch || st_next.ref_lost) begin
				st_next.lk = LK_IDLE;
			end else if (match) begin
				st_next.lk = LK_LOCKED;
			end
		end else if (m_rise) begin
			// A stopped reference freezes this path, so lock may persist
			if (!freq_ok) begin
				st_next.lk   = LK_IDLE;
				st_next.qual = 9'h000;
			end else if (st_reg.lk != LK_LOCKED) begin
				st_next.qual = qual_inc;
				st_next.lk   = (qual_inc >= qual_target) ? LK_LOCKED : LK_QUAL;
			end
		end

		st_next.lock_n = (st_next.lk != LK_LOCKED);
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg          <= '0;
			st_reg.prescale <= `PRESCALE_RST;
			st_reg.out_div  <= `OUT_DIV_RST;
			st_reg.loop_cfg <= `LOOP_CFG_RST;
			st_reg.lk       <= LK_IDLE;
			st_reg.lock_n   <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata      = st_reg.rdata;
	assign pready      = psel & penable;
	assign pslverr     = psel & penable & ~addr_ok;
	assign clk_out     = v_clk;
	assign lock_n      = st_reg.lock_n;
	// Skew circuits work in oscillator periods, so coarse mode only flags them
	assign cp_code     = st_reg.loop_cfg[`LC_CP_LSB +: 4];
	assign res_code    = st_reg.loop_cfg[`LC_RES_LSB +: 3];
	assign coarse_skew = st_reg.loop_cfg[`LC_COARSE_BIT];
endmodule

// *** core/pll_cfg.svh ***
// Address map, field layout and timing counts of the clock divider and lock detector
`ifndef PLL_CFG_SVH
`define PLL_CFG_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ADDR_PRESCALE     8'h00
`define ADDR_OUT_DIV      8'h04
`define ADDR_LOOP_CFG     8'h08
`define ADDR_STATUS       8'h0c

// ****************************************************************
// Field positions
// ****************************************************************
`define PS_M_LSB          0
`define PS_N_LSB          8
`define VD_FIELD_W        5
`define LC_FBK_LSB        0
`define LC_MODE_BIT       3
`define LC_QUAL_LSB       4
`define LC_CP_LSB         12
`define LC_RES_LSB        16
`define LC_COARSE_BIT     19
`define ST_LOCK_BIT       0
`define ST_BYPASS_BIT     1
`define ST_QUAL_LSB       2

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define PRESCALE_RST      32'h0000_0000
`define OUT_DIV_RST       32'h0000_0000
`define LOOP_CFG_RST      32'h0000_00f0
`define FBK_SEL_MAX       3'h4
`define CP_CODE_MAX       4'hd
`define RES_CODE_MAX      3'h5
`define QUAL_MIN          9'h010
`define QUAL_MAX          9'h100
`define NUM_OUT           5

// ****************************************************************
// Timing counts in cycles of clk
// ****************************************************************
`define PHASE_WIN_CYC     3'h2
`define REF_LOSS_CYC      10'h3ff

`endif

// *** core/pll_pkg.sv ***
// Types shared by the divider and lock detector files
package pll_pkg;

	// Lock detector states, Gray coded along idle, qualify, locked
	typedef enum logic [1:0] {
		LK_IDLE   = 2'b00,
		LK_QUAL   = 2'b01,
		LK_LOCKED = 2'b11
	} lock_state_t;

	typedef logic [4:0] div_code_t;
	typedef logic [6:0] div_ratio_t;

endpackage

// *** core/edge_sync.sv ***
// Three-flop synchroniser with a registered rising-edge pulse
`timescale 1ns/1ns
module edge_sync (
	input  wire logic clk,   // System clock
	input  wire logic rst,   // Synchronous reset, active high
	input  wire logic pin,   // Asynchronous input
	output logic      level, // Synchronised level
	output logic      rise   // One-cycle pulse on a rising edge
);
	import pll_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic rise;
	} sync_st_t;

	sync_st_t st_reg;
	sync_st_t st_next;

	always_comb begin
		st_next      = st_reg;
		st_next.s1   = pin;
		st_next.s2   = st_reg.s1;
		st_next.s3   = st_reg.s2;
		// Only s2 and s3 feed the edge test; s1 may be metastable
		st_next.rise = st_reg.s2 & ~st_reg.s3;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign level = st_reg.s3;
	assign rise  = st_reg.rise;
endmodule

// *** core/ratio_divider.sv ***
// Integer clock divider stepped by source-edge enable pulses
`timescale 1ns/1ns
module ratio_divider (
	input  wire logic                clk,     // System clock
	input  wire logic                rst,     // Synchronous reset, active high
	input  wire logic                src_en,  // One pulse per source rising edge
	input  wire pll_pkg::div_ratio_t ratio,   // Division ratio, 1 or more
	input  wire pll_pkg::div_ratio_t high,    // Source edges the output stays high
	output logic                     clk_out, // Divided clock level
	output logic                     rise     // Pulse when the divided clock rises
);
	import pll_pkg::*;

	typedef struct packed {
		div_ratio_t cnt;
		logic       out;
		logic       rise;
	} div_st_t;

	div_st_t    st_reg;
	div_st_t    st_next;
	div_ratio_t cnt_inc;

	always_comb begin
		st_next      = st_reg;
		st_next.rise = 1'b0;
		cnt_inc      = st_reg.cnt + 7'h01;
		if (src_en) begin
			// A ratio changed below the count wraps at once instead of running out
			st_next.cnt  = (cnt_inc >= ratio) ? 7'h00 : cnt_inc;
			st_next.rise = (st_next.cnt == 7'h00);
			// Ratio one passes each source edge through as a one-cycle high
			st_next.out  = (ratio == 7'h01) ? 1'b1 : (st_next.cnt < high);
		end else if (ratio == 7'h01) begin
			st_next.out = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign clk_out = st_reg.out;
	assign rise    = st_reg.rise;
endmodule

// *** tb/pll_chk.sv ***
// Concurrent checks on the ports of the divider and lock detector
`timescale 1ns/1ns
module pll_chk (
	input wire logic        clk,         // Clock
	input wire logic        rst,         // Reset
	input wire logic        psel,        // APB
	input wire logic        penable,     // APB
	input wire logic        pwrite,      // APB
	input wire logic [7:0]  paddr,       // APB
	input wire logic [31:0] pwdata,      // APB
	input wire logic [31:0] prdata,      // APB
	input wire logic        pready,      // APB
	input wire logic        pslverr,     // APB
	input wire logic        ref_in,      // Reference pin
	input wire logic        osc_in,      // Oscillator pin
	input wire logic        bypass_in,   // Bypass pin
	input wire logic [4:0]  clk_out,     // Divided clocks
	input wire logic        lock_n,      // Lock, low active
	input wire logic [3:0]  cp_code,     // Current code
	input wire logic [2:0]  res_code,    // Resistor code
	input wire logic        coarse_skew  // Coarse skew
);
	logic       ref_q;
	logic [3:0] since_ref;

	// Cycles since the last sampled reference rise; saturates so it never wraps
	always_ff @(posedge clk) begin
		ref_q <= ref_in;
		if (rst) begin
			since_ref <= 4'hf;
		end else if (ref_in && !ref_q) begin
			since_ref <= 4'h0;
		end else if (since_ref != 4'hf) begin
			since_ref <= since_ref + 4'h1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence apb_access;
		psel && penable;
	endsequence
	sequence bypass_held;
		bypass_in [*5];
	endsequence
	sequence ref_quiet;
		(bypass_in && !ref_in) [*8];
	endsequence

	// ****************************************************************
	// Assertions
	// ****************************************************************
	ready_zero_wait_a: assert property (pready == (psel && penable))
		else $error("pready differs from access phase");
	err_only_access_a: assert property (pslverr |-> apb_access)
		else $error("pslverr outside access phase");
	err_unmapped_a: assert property (apb_access
		|-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
		else $error("pslverr wrong for address");
	read_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("prdata moved outside setup");
	reset_idle_a: assert property (disable iff (1'b0) rst |=> lock_n && clk_out == 5'h00)
		else $error("outputs not idle after reset");
	bypass_unlock_a: assert property (bypass_held |=> lock_n)
		else $error("lock shown in bypass");
	bypass_quiet_a: assert property (ref_quiet |=> $stable(clk_out))
		else $error("outputs moved without prescaled edges");
	lock_after_ref_a: assert property ($fell(lock_n) |-> since_ref <= 4'ha)
		else $error("lock asserted without reference edge");
	cp_range_a: assert property (cp_code <= 4'hd)
		else $error("current code out of range");
	res_range_a: assert property (res_code <= 3'h5)
		else $error("resistor code out of range");
endmodule

// *** tb/clock_source.sv ***
// Reference clock source and free-running oscillator facing the divider block
`timescale 1ns/1ns
module clock_source (
	input  wire logic       clk,     // Bench clock
	input  wire logic       ref_run, // Reference toggles while high
	input  wire logic [7:0] ref_per, // Reference period in clk cycles, 8 or more
	output logic            ref_in,  // Reference pin, low while stopped
	output logic            osc_in   // Oscillator pin, four clk cycles a period
);
	logic [7:0] ref_cnt;
	logic [1:0] osc_cnt;

	initial begin
		ref_cnt = 8'h00;
		osc_cnt = 2'h0;
		ref_in  = 1'b0;
		osc_in  = 1'b0;
	end

	// Fixed high time with a variable period, so the duty cycle moves with the period
	always @(posedge clk) begin
		osc_cnt <= osc_cnt + 2'h1;
		osc_in  <= osc_cnt[1];
		if (!ref_run) begin
			ref_cnt <= 8'h00;
			ref_in  <= 1'b0;
		end else begin
			ref_cnt <= (ref_cnt >= ref_per - 8'h01) ? 8'h00 : ref_cnt + 8'h01;
			ref_in  <= (ref_cnt < 8'h03);
		end
	end
endmodule

// *** tb/pll_divider_and_lock_detect_bench.sv ***
// Self-checking bench for the divider and lock detector block
`timescale 1ns/1ns
`include "pll_cfg.svh"
bind pll_divider_and_lock_detect pll_chk pll_chk_i (.clk(clk), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ref_in(ref_in), .osc_in(osc_in),
	.bypass_in(bypass_in), .clk_out(clk_out), .lock_n(lock_n), .cp_code(cp_code),
	.res_code(res_code), .coarse_skew(coarse_skew));
module pll_divider_and_lock_detect_bench;
	logic        clk, rst, psel, penable, pwrite, bypass_in, ref_run;
	logic        pready, pslverr, er, ref_in, osc_in, lock_n, coarse_skew;
	logic [7:0]  paddr, ref_per;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  clk_out;
	logic [3:0]  cp_code;
	logic [2:0]  res_code;
	int          err_count, compares, n;
	logic [31:0] rst_val [4] = '{32'h0, 32'h0, 32'h0000_00f0, 32'h0};
	int          vcode [5]   = '{0, 1, 2, 6, 31};

	pll_divider_and_lock_detect pll_divider_and_lock_detect_i (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ref_in(ref_in), .osc_in(osc_in),
		.bypass_in(bypass_in), .clk_out(clk_out), .lock_n(lock_n), .cp_code(cp_code),
		.res_code(res_code), .coarse_skew(coarse_skew));
	clock_source clock_source_i (.clk(clk), .ref_run(ref_run), .ref_per(ref_per),
		.ref_in(ref_in), .osc_in(osc_in));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Ends at a falling edge so that register side effects have landed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask

	task automatic run_ref(input logic [7:0] per, input logic on);
		@(posedge clk);
		ref_per <= per;
		ref_run <= on;
		@(negedge clk);
	endtask

	// Second full rise-to-rise interval, so a source switch cannot shorten it
	task automatic period(input int k, output int p);
		logic prv;
		for (int r = 0; r < 3; r++) begin
			p = 0;
			do begin
				prv = clk_out[k];
				@(negedge clk);
				p++;
			end while (!(prv === 1'b0 && clk_out[k] === 1'b1) && p < 3000);
		end
	endtask

	task automatic wait_lock(input logic lvl, input int lim);
		n = 0;
		while (lock_n !== lvl && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		err_count = 0;
		compares  = 0;
		rst       = 1'b1;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		bypass_in = 1'b0;
		ref_run   = 1'b0;
		ref_per   = 8'h10;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check(lock_n, 1'b1);
		check(clk_out, 5'h00);
		apb(1'b1, `ADDR_STATUS, 32'hffff_ffff);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			check(rd, rst_val[i]);
		end
		apb(1'b0, 8'h10, 32'h0);
		check({er, rd}, 33'h1_0000_0000);
		for (int i = 0; i < 16; i++) begin
			apb(1'b1, `ADDR_LOOP_CFG, 32'h0008_00f0 | (32'(i) << 12) | (32'(i % 8) << 16));
			check({coarse_skew, res_code, cp_code},
				{1'b1, (i % 8 > 5) ? 3'h5 : 3'(i % 8), (i > 13) ? 4'hd : 4'(i)});
		end
		apb(1'b1, `ADDR_LOOP_CFG, 32'h000f_f0ff);
		apb(1'b0, `ADDR_LOOP_CFG, 32'h0);
		check(rd, 32'h000d_d0fc);
		apb(1'b1, `ADDR_OUT_DIV, 32'h01f3_0820);
		for (int k = 0; k < 5; k++) begin
			period(k, n);
			check(n, 8 * (vcode[k] + 1));
		end
		// Prescalers at two, feedback from the second output divider, frequency mode
		apb(1'b1, `ADDR_PRESCALE, 32'h0000_0101);
		apb(1'b1, `ADDR_LOOP_CFG, 32'h0000_00f9);
		run_ref(8'd16, 1'b1);
		wait_lock(1'b0, 2000);
		check(n >= 480 && n < 700, 1'b1);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		check(rd[1:0], 2'b01);
		run_ref(8'd24, 1'b1);
		wait_lock(1'b1, 200);
		check(n < 200, 1'b1);
		run_ref(8'd16, 1'b1);
		wait_lock(1'b0, 2000);
		check(n >= 480 && n < 2000, 1'b1);
		run_ref(8'd16, 1'b0);
		repeat (1100) @(negedge clk);
		check(lock_n, 1'b0);
		apb(1'b1, `ADDR_LOOP_CFG, 32'h0000_00f1);
		wait_lock(1'b1, 1100);
		check(n < 1100, 1'b1);
		run_ref(8'd17, 1'b1);
		wait_lock(1'b0, 1500);
		check(n < 1500, 1'b1);
		run_ref(8'd17, 1'b0);
		wait_lock(1'b1, 1100);
		check(n < 1100, 1'b1);
		// Drift alone may drop lock; with no reference it must never come back
		repeat (1100) @(negedge clk);
		check(lock_n, 1'b1);
		@(posedge clk);
		bypass_in <= 1'b1;
		run_ref(8'd16, 1'b1);
		period(2, n);
		check(n, 96);
		check(lock_n, 1'b1);
		apb(1'b0, `ADDR_STATUS, 32'h0);
		check(rd[1:0], 2'b10);
		@(posedge clk);
		bypass_in <= 1'b0;
		complete_run;
	end

	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		complete_run;
	end
endmodule
